// ### rtl/lpnp_regif.sv
/*
 * Management serial slave serving the read-only link partner page register.
 * Assumes MDC is slow enough that each phase lasts at least four clk cycles,
 * and that other registers of the device are answered elsewhere.
 */
`timescale 1ns/10ps
module lpnp_regif (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   // Device address
   input wire logic [4:0] phy_address,
   // Auto-negotiation receiver
   input wire lpnp_pkg::lpnp_rx_type rx,
   input wire logic an_complete,
   input wire logic np_supported
);

   // Address match, used only to qualify read frames
   function automatic logic frame_hits(input logic [4:0] phy, input logic [4:0] own, input logic [4:0] regad);
      frame_hits = (phy == own) && (regad == lpnp_pkg::REG_OFFSET);
   endfunction : frame_hits

   // Two-stage synchronisers for the pins, plus one stage for edge finding
   logic [1:0] sync_first;
   logic [1:0] sync_second;
   logic mdc_prev;
   wire logic [1:0] pin_raw;
   wire logic mdc_s;
   wire logic mdio_s;
   wire logic mdc_rise;

   assign pin_raw = {mdio_in, mdc};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               sync_first[g] <= 1'b0;
               sync_second[g] <= 1'b0;
            end else begin
               sync_first[g] <= pin_raw[g];
               sync_second[g] <= sync_first[g];
            end
         end
      end
   endgenerate

   assign mdc_s = sync_second[0];
   assign mdio_s = sync_second[1];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mdc_prev <= 1'b0;
      end else begin
         mdc_prev <= mdc_s;
      end
   end

   assign mdc_rise = mdc_s && !mdc_prev;

   // Register content
   lpnp_pkg::lpnp_page_type view;

   lpnp_capture u_capture (
      .clk(clk),
      .rstn(rstn),
      .rx(rx),
      .an_complete(an_complete),
      .np_supported(np_supported),
      .view(view)
   );

   // Frame state
   lpnp_pkg::lpnp_state_type state;
   lpnp_pkg::lpnp_state_type next_state;
   logic [5:0] ones;
   logic [5:0] next_ones;
   logic [4:0] count;
   logic [4:0] next_count;
   logic [1:0] opcode;
   logic [4:0] phy_field;
   logic [4:0] reg_field;
   logic read_hit;
   logic next_read_hit;
   logic [15:0] shifter;
   logic [15:0] next_shifter;
   logic next_mdio_out;
   logic next_mdio_oe;
   wire logic [4:0] count_inc;
   wire logic [5:0] ones_inc;
   wire logic field_done_op;
   wire logic field_done_addr;
   wire logic turn_done;
   wire logic data_done;
   wire logic hit_now;
   wire logic read_take;

   assign count_inc = count + 5'h01;
   assign ones_inc = (ones == lpnp_pkg::PREAMBLE_ONES) ? ones : ones + 6'h01;
   assign field_done_op = (count_inc == lpnp_pkg::OP_BITS);
   assign field_done_addr = (count_inc == lpnp_pkg::ADDR_BITS);
   assign turn_done = (count_inc == lpnp_pkg::TURN_BITS);
   assign data_done = (count_inc == lpnp_pkg::DATA_BITS);
   // Register address completes with the bit sampled now
   assign hit_now = frame_hits(phy_field, phy_address, {reg_field[3:0], mdio_s});
   // Only a matching read loads data, so an unanswered frame keeps the data line low
   assign read_take = (opcode == lpnp_pkg::OP_READ) && hit_now;

   always_comb begin
      next_state = state;
      next_ones = ones;
      next_count = count;
      next_read_hit = read_hit;
      next_shifter = shifter;
      next_mdio_out = mdio_out;
      next_mdio_oe = mdio_oe;
      if (mdc_rise) begin
         case (state)
            lpnp_pkg::ST_PREAMBLE: begin
               if (mdio_s) begin
                  next_ones = ones_inc;
               end else if (ones == lpnp_pkg::PREAMBLE_ONES) begin
                  next_state = lpnp_pkg::ST_START;
               end else begin
                  next_ones = 6'h00;
               end
            end
            lpnp_pkg::ST_START: begin
               next_ones = 6'h00;
               next_count = 5'h00;
               next_state = mdio_s ? lpnp_pkg::ST_OP : lpnp_pkg::ST_PREAMBLE;
            end
            lpnp_pkg::ST_OP: begin
               next_count = field_done_op ? 5'h00 : count_inc;
               if (field_done_op) begin
                  next_state = lpnp_pkg::ST_PHY;
               end
            end
            lpnp_pkg::ST_PHY: begin
               next_count = field_done_addr ? 5'h00 : count_inc;
               if (field_done_addr) begin
                  next_state = lpnp_pkg::ST_REG;
               end
            end
            lpnp_pkg::ST_REG: begin
               next_count = field_done_addr ? 5'h00 : count_inc;
               if (field_done_addr) begin
                  next_state = lpnp_pkg::ST_TURN;
                  // Only reads are answered; a write that hits is dropped
                  next_read_hit = read_take;
                  next_shifter = read_take ? view : lpnp_pkg::REG_RESET;
               end
            end
            lpnp_pkg::ST_TURN: begin
               next_count = turn_done ? 5'h00 : count_inc;
               if (turn_done) begin
                  next_state = lpnp_pkg::ST_DATA;
                  next_mdio_out = shifter[15];
                  next_shifter = {shifter[14:0], 1'b0};
               end else begin
                  // Second turnaround bit is driven low by the slave
                  next_mdio_oe = read_hit;
                  next_mdio_out = 1'b0;
               end
            end
            lpnp_pkg::ST_DATA: begin
               next_count = data_done ? 5'h00 : count_inc;
               if (data_done) begin
                  next_state = lpnp_pkg::ST_PREAMBLE;
                  next_mdio_oe = 1'b0;
                  next_mdio_out = 1'b0;
                  next_read_hit = 1'b0;
               end else begin
                  next_mdio_out = shifter[15];
                  next_shifter = {shifter[14:0], 1'b0};
               end
            end
            default: begin
               next_state = lpnp_pkg::ST_PREAMBLE;
               next_ones = 6'h00;
               next_count = 5'h00;
               next_mdio_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= lpnp_pkg::ST_PREAMBLE;
         ones <= 6'h00;
         count <= 5'h00;
         read_hit <= 1'b0;
         shifter <= lpnp_pkg::REG_RESET;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else begin
         state <= next_state;
         ones <= next_ones;
         count <= next_count;
         read_hit <= next_read_hit;
         shifter <= next_shifter;
         mdio_out <= next_mdio_out;
         mdio_oe <= next_mdio_oe;
      end
   end

   // Header field capture; write data is never stored anywhere
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         opcode <= 2'h0;
         phy_field <= 5'h00;
         reg_field <= 5'h00;
      end else if (mdc_rise) begin
         if (state == lpnp_pkg::ST_OP) begin
            opcode <= {opcode[0], mdio_s};
         end
         if (state == lpnp_pkg::ST_PHY) begin
            phy_field <= {phy_field[3:0], mdio_s};
         end
         if (state == lpnp_pkg::ST_REG) begin
            reg_field <= {reg_field[3:0], mdio_s};
         end
      end
   end

endmodule : lpnp_regif

// ### shared/lpnp_pkg.sv
/*
 * Package for the link partner next-page status register: field layout,
 * reset value, management frame constants and the carrier types.
 * Assumes a single 200 MHz clock domain shared by every user.
 */
package lpnp_pkg;

   // Register placement and reset
   localparam logic [4:0] REG_OFFSET = 5'h05;
   localparam logic [15:0] REG_RESET = 16'h0000;

   // Field positions inside the 16-bit word
   localparam int POS_MORE_PAGES = 15;
   localparam int POS_ACK = 14;
   localparam int POS_MESSAGE_PAGE = 13;
   localparam int POS_CAN_COMPLY = 12;
   localparam int POS_TOGGLE = 11;
   localparam int CODE_MSB = 10;
   localparam int CODE_WIDTH = 11;

   // Management frame layout
   localparam logic [5:0] PREAMBLE_ONES = 6'h20;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] OP_BITS = 5'h02;
   localparam logic [4:0] ADDR_BITS = 5'h05;
   localparam logic [4:0] TURN_BITS = 5'h02;
   localparam logic [4:0] DATA_BITS = 5'h10;

   // Received link code word, laid out as the register reads
   typedef struct packed {
      logic partner_more_pages;
      logic partner_ack;
      logic message_page_flag;
      logic partner_can_comply;
      logic partner_toggle;
      logic [CODE_WIDTH-1:0] code;
   } lpnp_page_type;

   // One page handed over by the auto-negotiation receiver
   typedef struct packed {
      logic valid;
      logic is_next_page;
      lpnp_page_type page;
   } lpnp_rx_type;

   typedef enum logic [2:0] {
      ST_PREAMBLE = 3'b000,
      ST_START = 3'b001,
      ST_OP = 3'b010,
      ST_PHY = 3'b011,
      ST_REG = 3'b100,
      ST_TURN = 3'b101,
      ST_DATA = 3'b110
   } lpnp_state_type;

endpackage : lpnp_pkg

// ### rtl/lpnp_capture.sv
/*
 * Holds the base page and the next page received from the link partner and
 * presents whichever one the register should show.
 * Assumes the receiver hands over pages on the same clock, one cycle each.
 */
`timescale 1ns/10ps
module lpnp_capture (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // From the auto-negotiation receiver
   input wire lpnp_pkg::lpnp_rx_type rx,
   input wire logic an_complete,
   input wire logic np_supported,
   // Register view
   output lpnp_pkg::lpnp_page_type view
);

   lpnp_pkg::lpnp_page_type base_word;
   lpnp_pkg::lpnp_page_type next_word;
   lpnp_pkg::lpnp_page_type next_view;
   wire logic take_base;
   wire logic take_next;
   wire logic show_next;

   assign take_base = rx.valid && !rx.is_next_page;
   assign take_next = rx.valid && rx.is_next_page;
   // Base abilities until negotiation is done with next pages supported, then the next page word
   assign show_next = an_complete && np_supported;
   assign next_view = show_next ? next_word : base_word;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         base_word <= lpnp_pkg::REG_RESET;
         next_word <= lpnp_pkg::REG_RESET;
         view <= lpnp_pkg::REG_RESET;
      end else begin
         if (take_base) begin
            base_word <= rx.page;
         end
         if (take_next) begin
            next_word <= rx.page;
         end
         view <= next_view;
      end
   end

endmodule : lpnp_capture

// ### verif/lpnp_regif_asserts.sv
/* Port-level checks on the partner page register slave.
   Assumes the bench runs mdc at 8 clk high and 8 clk low. */
`timescale 1ns/10ps
module lpnp_regif_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Management pins
   input wire logic mdc,
   input wire logic mdio_in,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   // Receiver side
   input wire logic [4:0] phy_address,
   input wire lpnp_pkg::lpnp_rx_type rx,
   input wire logic an_complete,
   input wire logic np_supported
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [8:0] oe_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) oe_cnt <= 9'h000;
      else oe_cnt <= mdio_oe ? oe_cnt + 9'h001 : 9'h000;
   end
   property p_ta_zero; $rose(mdio_oe) |-> !mdio_out; endproperty
   a_ta_zero: assert property (p_ta_zero) else $error("turnaround bit not zero");
   property p_out_on_rise; $changed(mdio_out) |-> $past(mdc, 2); endproperty
   a_out_on_rise: assert property (p_out_on_rise) else $error("data moved off mdc rise");
   property p_oe_on_rise; $changed(mdio_oe) |-> $past(mdc, 2); endproperty
   a_oe_on_rise: assert property (p_oe_on_rise) else $error("enable moved off mdc rise");
   property p_quiet; !mdio_oe |-> !mdio_out; endproperty
   a_quiet: assert property (p_quiet) else $error("data high while not driving");
   property p_oe_hold; $rose(mdio_oe) |-> mdio_oe [*8]; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("enable dropped early");
   property p_oe_max; mdio_oe |-> oe_cnt < 9'h118; endproperty
   a_oe_max: assert property (p_oe_max) else $error("drive longer than 17 mdc periods");
   property p_oe_min; $fell(mdio_oe) |-> oe_cnt > 9'h100; endproperty
   a_oe_min: assert property (p_oe_min) else $error("drive shorter than 16 mdc periods");
   property p_out_stands; $changed(mdio_out) |=> $stable(mdio_out) [*6]; endproperty
   a_out_stands: assert property (p_out_stands) else $error("data bit did not stand");
   c_read: cover property ($rose(mdio_oe));
   c_done: cover property ($fell(mdio_oe));
   c_next: cover property (rx.valid && rx.is_next_page && an_complete && np_supported);
endmodule : lpnp_regif_asserts
bind lpnp_regif lpnp_regif_asserts u_lpnp_regif_asserts (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_in),
   .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_address(phy_address), .rx(rx), .an_complete(an_complete),
   .np_supported(np_supported));

// ### verif/lpnp_partner.sv
/* Link partner model handing received pages to the register.
   Assumes the bench calls send from its own thread. */
`timescale 1ns/10ps
module lpnp_partner (
   // Clock
   input wire logic clk,
   // Received page
   output lpnp_pkg::lpnp_rx_type rx
);
   initial rx = '0;
   // Idle page bits show the inverse so stale data is never reused
   task send(input logic np, input logic [15:0] pg, input int gap);
      repeat (gap + 1) @(posedge clk);
      #1;
      rx = {1'b1, np, pg};
      @(posedge clk);
      #1;
      rx = {1'b0, np, ~pg};
   endtask : send
endmodule : lpnp_partner

// ### verif/link_partner_next_page_reg_tb.sv
/* Self-checking bench for the partner page register slave.
   Assumes the slave answers at address 5'h01 only. */
`timescale 1ns/10ps
module link_partner_next_page_reg_tb;
   logic clk, rstn, mdc, m_oe, m_val, an_complete, np_supported, mdio_out, mdio_oe;
   wire logic mdio_wire;
   lpnp_pkg::lpnp_rx_type rx;
   int error_cnt, n_tests;
   logic [15:0] rd;
   logic [15:0] pats [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h07FF, 16'h0001};
   // Released line floats high through the pull-up
   assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_val : 1'b1);
   lpnp_regif u_lpnp_regif (.clk(clk), .rstn(rstn), .mdc(mdc), .mdio_in(mdio_wire), .mdio_out(mdio_out),
      .mdio_oe(mdio_oe), .phy_address(5'h01), .rx(rx), .an_complete(an_complete), .np_supported(np_supported));
   lpnp_partner u_lpnp_partner (.clk(clk), .rx(rx));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task tick(input int n); repeat (n) @(posedge clk); #1; endtask : tick
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task close_out;
      $display("Checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out
   // One frame, mdc 8 clk low then 8 clk high per bit
   task frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] wd);
      logic [63:0] f;
      f = {32'hFFFFFFFF, 2'b01, op, phy, ra, 2'b10, wd};
      for (int i = 0; i < 64; i++) begin
         mdc = 1'b0;
         m_oe = (op == lpnp_pkg::OP_WRITE) || (i < 46);
         m_val = f[63-i];
         tick(8);
         if (i >= 48) rd = {rd[14:0], mdio_wire};
         mdc = 1'b1;
         tick(8);
      end
      mdc = 1'b0;
      m_oe = 1'b0;
      tick(8);
   endtask : frame
   task rd_chk(input string name, input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
      frame(lpnp_pkg::OP_READ, phy, ra, 16'h0000);
      check(name, rd, exp);
   endtask : rd_chk
   task s_select;
      u_lpnp_partner.send(1'b0, 16'h01E1, 0);
      u_lpnp_partner.send(1'b1, 16'hA5C3, 3);
      tick(4);
      rd_chk("base_view", 5'h01, lpnp_pkg::REG_OFFSET, 16'h01E1);
      an_complete = 1'b1;
      np_supported = 1'b0;
      tick(4);
      rd_chk("base_no_np", 5'h01, lpnp_pkg::REG_OFFSET, 16'h01E1);
      np_supported = 1'b1;
      tick(4);
      rd_chk("next_view", 5'h01, lpnp_pkg::REG_OFFSET, 16'hA5C3);
   endtask : s_select
   task s_fields;
      foreach (pats[k]) begin
         u_lpnp_partner.send(1'b1, 16'h1234, 0);
         u_lpnp_partner.send(1'b1, pats[k], 1);
         u_lpnp_partner.send(1'b0, 16'hFFFF, 1);
         tick(4);
         rd_chk("field", 5'h01, lpnp_pkg::REG_OFFSET, pats[k]);
      end
   endtask : s_fields
   task s_write;
      frame(lpnp_pkg::OP_WRITE, 5'h01, lpnp_pkg::REG_OFFSET, 16'hBFFE);
      rd_chk("after_write", 5'h01, lpnp_pkg::REG_OFFSET, 16'h0001);
   endtask : s_write
   task s_other;
      rd_chk("other_phy", 5'h02, lpnp_pkg::REG_OFFSET, 16'hFFFF);
      rd_chk("other_reg", 5'h01, 5'h06, 16'hFFFF);
   endtask : s_other
   task s_rereset;
      rstn = 1'b0;
      tick(4);
      rstn = 1'b1;
      tick(4);
      rd_chk("mid_reset", 5'h01, lpnp_pkg::REG_OFFSET, lpnp_pkg::REG_RESET);
   endtask : s_rereset
   initial begin
      {rstn, mdc, m_oe, m_val, an_complete, np_supported} = 6'h00;
      tick(4);
      rstn = 1'b1;
      tick(3);
      rd_chk("reset_word", 5'h01, lpnp_pkg::REG_OFFSET, lpnp_pkg::REG_RESET);
      s_select();
      s_fields();
      s_write();
      s_other();
      s_rereset();
      close_out();
   end
   // The 16 frames of about 1024 clk each fit well inside this span
   initial begin
      #250000;
      error_cnt++;
      close_out();
   end
endmodule : link_partner_next_page_reg_tb
